// *** cis_input_sequencer.v ***
`default_nettype none
`include "cis_map.vh"
module cis_input_sequencer #(
    parameter SHOW_CYCLES = `CIS_SHOW_CYCLES,
    parameter TW = 25
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire [9:0] sw,
    input wire [3:0] key,
    input wire fault_in,
    input wire [6:0] result_digit_in0,
    input wire [6:0] result_digit_in1,
    input wire [6:0] result_digit_in2,
    input wire [6:0] result_digit_in3,
    input wire [6:0] conv_digit0,
    input wire [6:0] conv_digit1,
    input wire [6:0] conv_digit2,
    input wire [6:0] conv_digit3,
    output reg [6:0] seg_code0,
    output reg [6:0] seg_code1,
    output reg [6:0] seg_code2,
    output reg [6:0] seg_code3,
    output reg [2:0] led_green,
    output reg led_done,
    output reg sys_reset,
    output reg [1:0] result_source_select,
    output reg [26:0] pv_out,
    output reg [26:0] fv_out,
    output reg [6:0] rate_out,
    output reg [5:0] years_out,
    output reg rate_unit_go,
    output reg future_unit_go,
    output reg doubling_unit_go,
    output reg converter_go
);
    // ****************************************
    // States
    // ****************************************
    localparam [3:0] ST_RESET = 4'h0;
    localparam [3:0] ST_READY = 4'h1;
    localparam [3:0] ST_FV_CAP = 4'h2;
    localparam [3:0] ST_FV_SHOW = 4'h3;
    localparam [3:0] ST_PV_CAP = 4'h4;
    localparam [3:0] ST_PV_SHOW = 4'h5;
    localparam [3:0] ST_RATE_CAP = 4'h6;
    localparam [3:0] ST_RATE_SHOW = 4'h7;
    localparam [3:0] ST_YRS_CAP = 4'h8;
    localparam [3:0] ST_YRS_SHOW = 4'h9;
    localparam [3:0] ST_LAUNCH_LO = 4'hA;
    localparam [3:0] ST_LAUNCH_HI = 4'hB;
    localparam [3:0] ST_RESULT = 4'hC;
    localparam [TW-1:0] SHOW_LOAD = SHOW_CYCLES[TW-1:0] - 1'b1;

    // ****************************************
    // Pin synchronisation and press detection
    // ****************************************
    wire [13:0] pins_s;
    wire [9:0] sw_s = pins_s[9:0];
    wire [3:0] key_s = pins_s[13:10];
    reg [3:0] key_prev;
    reg chord;
    wire sw_restart;
    wire core_rst_n = hresetn & ~chord;
    wire [3:0] press = key_s & ~key_prev;
    wire any_load = press[0] | press[1] | press[2];
    reg [3:0] state;
    reg [TW-1:0] timer;

    cis_sync #(
        .WIDTH(14)
    ) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in({key, sw}),
        .sync_out(pins_s)
    );

    cis_ahb_regs u_regs (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .status_word({25'h0000000, fault_in, result_source_select, 4'h0} | {28'h0000000, state}),
        .pv_word({5'h00, pv_out}),
        .fv_word({5'h00, fv_out}),
        .rate_years_word({18'h00000, years_out, 1'b0, rate_out}),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .restart_pulse(sw_restart)
    );

    // The chord is registered so that a bouncing button cannot glitch the async clear.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chord <= 1'b0;
            key_prev <= 4'h0;
        end else begin
            chord <= ((&key_s) & ~sw_s[9]) | sw_restart;
            key_prev <= key_s;
        end
    end

    // ****************************************
    // Helpers
    // ****************************************
    function [26:0] load_field;
        input [26:0] old;
        input [2:0] btn;
        input [9:0] swv;
        begin
            load_field = old;
            if (btn[0]) begin
                load_field[9:0] = swv;
            end else if (btn[1]) begin
                load_field[19:10] = swv;
            end else if (btn[2]) begin
                load_field[26:20] = swv[6:0];
            end
        end
    endfunction

    function [2:0] mode_leds;
        input [1:0] m;
        begin
            case (m)
                `CIS_MODE_RATE: mode_leds = 3'h1;
                `CIS_MODE_FUTURE: mode_leds = 3'h2;
                `CIS_MODE_DOUBLE: mode_leds = 3'h4;
                default: mode_leds = 3'h0;
            endcase
        end
    endfunction

    // ****************************************
    // Sequencer
    // ****************************************
    // Buttons act on their press edge, so a held button loads once and a held
    // button 3 cannot run through several states in a row.
    always @(posedge hclk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            state <= ST_RESET;
            pv_out <= 27'h0000000;
            fv_out <= 27'h0000000;
            rate_out <= `CIS_RATE_RESET;
            years_out <= `CIS_YEARS_RESET;
            result_source_select <= `CIS_MODE_NONE;
            sys_reset <= 1'b1;
            seg_code0 <= 7'h00;
            seg_code1 <= 7'h00;
            seg_code2 <= 7'h00;
            seg_code3 <= 7'h00;
            led_green <= 3'h0;
            led_done <= 1'b0;
            rate_unit_go <= 1'b1;
            future_unit_go <= 1'b1;
            doubling_unit_go <= 1'b1;
            converter_go <= 1'b1;
            timer <= {TW{1'b0}};
        end else begin
            led_green <= mode_leds(result_source_select);
            if (timer != {TW{1'b0}}) begin
                timer <= timer - 1'b1;
            end
            case (state)
                ST_RESET: begin
                    sys_reset <= 1'b1;
                    state <= ST_READY;
                end
                ST_READY: begin
                    sys_reset <= 1'b0;
                    seg_code0 <= `CIS_CH_M;
                    seg_code1 <= `CIS_CH_O;
                    seg_code2 <= `CIS_CH_D;
                    seg_code3 <= `CIS_CH_E;
                    if (press[0]) begin
                        result_source_select <= sw_s[1:0];
                    end
                    if (press[3] & sw_s[9]) begin
                        state <= ST_FV_CAP;
                    end
                end
                ST_FV_CAP: begin
                    if (result_source_select != `CIS_MODE_RATE) begin
                        state <= ST_PV_CAP;
                    end else begin
                        if (fault_in) begin
                            seg_code0 <= result_digit_in0;
                            seg_code1 <= result_digit_in1;
                            seg_code2 <= result_digit_in2;
                            seg_code3 <= result_digit_in3;
                        end else begin
                            seg_code0 <= `CIS_CH_SW8;
                            seg_code1 <= `CIS_CH_DASH;
                            seg_code2 <= `CIS_CH_F;
                            seg_code3 <= `CIS_CH_V;
                        end
                        if (any_load) begin
                            fv_out <= load_field(fv_out, press[2:0], sw_s);
                            timer <= SHOW_LOAD;
                            converter_go <= 1'b0;
                            state <= ST_FV_SHOW;
                        end else if (press[3] & sw_s[8]) begin
                            state <= ST_PV_CAP;
                        end
                    end
                end
                ST_PV_CAP: begin
                    if (result_source_select != `CIS_MODE_RATE &&
                        result_source_select != `CIS_MODE_FUTURE) begin
                        state <= ST_RATE_CAP;
                    end else begin
                        if (fault_in) begin
                            seg_code0 <= result_digit_in0;
                            seg_code1 <= result_digit_in1;
                            seg_code2 <= result_digit_in2;
                            seg_code3 <= result_digit_in3;
                        end else begin
                            seg_code0 <= `CIS_CH_SW7;
                            seg_code1 <= `CIS_CH_DASH;
                            seg_code2 <= `CIS_CH_P;
                            seg_code3 <= `CIS_CH_V;
                        end
                        if (any_load) begin
                            pv_out <= load_field(pv_out, press[2:0], sw_s);
                            timer <= SHOW_LOAD;
                            converter_go <= 1'b0;
                            state <= ST_PV_SHOW;
                        end else if (press[3] & sw_s[7]) begin
                            state <= ST_RATE_CAP;
                        end
                    end
                end
                ST_FV_SHOW, ST_PV_SHOW: begin
                    converter_go <= 1'b1;
                    seg_code0 <= conv_digit0;
                    seg_code1 <= conv_digit1;
                    seg_code2 <= conv_digit2;
                    seg_code3 <= conv_digit3;
                    if (timer == {TW{1'b0}}) begin
                        state <= (state == ST_FV_SHOW) ? ST_FV_CAP : ST_PV_CAP;
                    end
                end
                ST_RATE_CAP: begin
                    if (result_source_select != `CIS_MODE_FUTURE &&
                        result_source_select != `CIS_MODE_DOUBLE) begin
                        state <= ST_YRS_CAP;
                    end else begin
                        if (fault_in) begin
                            seg_code0 <= result_digit_in0;
                            seg_code1 <= result_digit_in1;
                            seg_code2 <= result_digit_in2;
                            seg_code3 <= result_digit_in3;
                        end else begin
                            seg_code0 <= `CIS_CH_SW6;
                            seg_code1 <= `CIS_CH_DASH;
                            seg_code2 <= `CIS_CH_I;
                            seg_code3 <= `CIS_CH_N;
                        end
                        if (press[0]) begin
                            rate_out <= sw_s[6:0];
                            timer <= SHOW_LOAD;
                            state <= ST_RATE_SHOW;
                        end else if (press[3] & sw_s[6]) begin
                            state <= ST_YRS_CAP;
                        end
                    end
                end
                ST_RATE_SHOW: begin
                    seg_code0 <= `CIS_CH_I;
                    seg_code1 <= `CIS_CH_N;
                    seg_code2 <= `CIS_CH_EQUALS;
                    seg_code3 <= rate_out;
                    if (timer == {TW{1'b0}}) begin
                        state <= ST_RATE_CAP;
                    end
                end
                ST_YRS_CAP: begin
                    if (result_source_select != `CIS_MODE_FUTURE &&
                        result_source_select != `CIS_MODE_RATE) begin
                        state <= ST_LAUNCH_LO;
                    end else begin
                        if (fault_in) begin
                            seg_code0 <= result_digit_in0;
                            seg_code1 <= result_digit_in1;
                            seg_code2 <= result_digit_in2;
                            seg_code3 <= result_digit_in3;
                        end else begin
                            seg_code0 <= `CIS_CH_SW5;
                            seg_code1 <= `CIS_CH_DASH;
                            seg_code2 <= `CIS_CH_Y;
                            seg_code3 <= `CIS_CH_R;
                        end
                        if (press[0]) begin
                            years_out <= sw_s[5:0];
                            timer <= SHOW_LOAD;
                            state <= ST_YRS_SHOW;
                        end else if (press[3] & sw_s[5]) begin
                            state <= ST_LAUNCH_LO;
                        end
                    end
                end
                ST_YRS_SHOW: begin
                    seg_code0 <= `CIS_CH_Y;
                    seg_code1 <= `CIS_CH_R;
                    seg_code2 <= `CIS_CH_EQUALS;
                    seg_code3 <= {1'b0, years_out};
                    if (timer == {TW{1'b0}}) begin
                        state <= ST_YRS_CAP;
                    end
                end
                ST_LAUNCH_LO: begin
                    state <= ST_LAUNCH_HI;
                    case (result_source_select)
                        `CIS_MODE_RATE: rate_unit_go <= 1'b0;
                        `CIS_MODE_FUTURE: future_unit_go <= 1'b0;
                        `CIS_MODE_DOUBLE: doubling_unit_go <= 1'b0;
                        default: state <= ST_READY;
                    endcase
                end
                ST_LAUNCH_HI: begin
                    case (result_source_select)
                        `CIS_MODE_RATE: rate_unit_go <= 1'b1;
                        `CIS_MODE_FUTURE: future_unit_go <= 1'b1;
                        `CIS_MODE_DOUBLE: doubling_unit_go <= 1'b1;
                        default: rate_unit_go <= 1'b1;
                    endcase
                    state <= ST_RESULT;
                end
                ST_RESULT: begin
                    // Only the chord, a soft restart or hresetn leaves this state.
                    seg_code0 <= result_digit_in0;
                    seg_code1 <= result_digit_in1;
                    seg_code2 <= result_digit_in2;
                    seg_code3 <= result_digit_in3;
                    led_done <= 1'b1;
                end
                default: begin
                    state <= ST_RESET;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// *** cis_map.vh ***
// Contract
// - Holding all four buttons with switch 9 off resets the controller asynchronously.
// - Reset clears present and future values, sets rate and years to one, mode 11.
// - System reset to outside units is high in reset, dropped first thing in ready.
// - Ready shows the mode prompt codes on the four digits.
// - In ready, button 0 loads switches 1..0 into the mode, which drives result select.
// - Mode 00 is interest rate, 01 future value, 10 doubling time.
// - One of three green indicators shows modes 00, 01 and 10; none lights in mode 11.
// - Leaving ready takes button 3 with switch 9; each later step its own switch.
// - In capture states an active range fault passes the external digits to the display.
// - Buttons 0, 1, 2 load switch fields into operand bits as the operand allows.
// - A load enters a display state with a fresh timer; present and future value loads pulse converter start low then high.
// - Future value capture is skipped unless mode is 00.
// - Future value capture prompt is 8, dash, F, V.
// - Future value capture advances on button 3 with switch 8.
// - Present value capture only in modes 00 and 01; prompt 7-PV; advance with switch 7.
// - Rate capture only in modes 01 and 10; prompt 6-in; advance with switch 6.
// - Rate display shows the rate directly after an in= label.
// - Years capture only in modes 01 and 00; prompt 5-YR; advance with switch 5.
// - Years display pads the six-bit years with a zero MSB after a YR= label.
// - First launch drives the mode's start line low; mode 11 returns to ready.
// - Second launch drives the mode's start line high, then shows the result.
`ifndef CIS_MAP_VH
`define CIS_MAP_VH

// ****************************************
// Register map
// ****************************************
`define CIS_REG_CTRL 8'h00
`define CIS_REG_STATUS 8'h04
`define CIS_REG_PV 8'h08
`define CIS_REG_FV 8'h0C
`define CIS_REG_RATE_YEARS 8'h10
`define CIS_CTRL_RESTART_BIT 0

// ****************************************
// Modes and reset values
// ****************************************
`define CIS_MODE_RATE 2'h0
`define CIS_MODE_FUTURE 2'h1
`define CIS_MODE_DOUBLE 2'h2
`define CIS_MODE_NONE 2'h3
`define CIS_RATE_RESET 7'h01
`define CIS_YEARS_RESET 6'h01

// ****************************************
// Timing
// ****************************************
`define CIS_CLK_MHZ 100
`define CIS_SHOW_TIME_MS 250
`define CIS_SHOW_CYCLES (`CIS_SHOW_TIME_MS * 1000 * `CIS_CLK_MHZ)

// ****************************************
// Segment decoder codes
// ****************************************
`define CIS_CH_M 7'h16
`define CIS_CH_O 7'h00
`define CIS_CH_D 7'h0D
`define CIS_CH_E 7'h0E
`define CIS_CH_DASH 7'h25
`define CIS_CH_F 7'h0F
`define CIS_CH_V 7'h1E
`define CIS_CH_P 7'h19
`define CIS_CH_I 7'h01
`define CIS_CH_N 7'h16
`define CIS_CH_Y 7'h22
`define CIS_CH_R 7'h1D
`define CIS_CH_EQUALS 7'h26
`define CIS_CH_SW8 7'h08
`define CIS_CH_SW7 7'h07
`define CIS_CH_SW6 7'h06
`define CIS_CH_SW5 7'h05

`endif

// *** cis_sync.v ***
`default_nettype none
// ****************************************
// Two-stage synchroniser for board pins
// ****************************************
module cis_sync #(
    parameter WIDTH = 14
) (
    input wire hclk,
    input wire hresetn,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage1;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stage1 <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule
`default_nettype wire

// *** cis_ahb_regs.v ***
`default_nettype none
`include "cis_map.vh"
// ****************************************
// AHB-Lite slave, zero wait states
// ****************************************
module cis_ahb_regs (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] status_word,
    input wire [31:0] pv_word,
    input wire [31:0] fv_word,
    input wire [31:0] rate_years_word,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    output reg restart_pulse
);
    reg wr_pend;
    reg [7:0] wr_addr;
    wire take = hsel & htrans[1] & hready;

    // Read data is fetched at the address phase so it stands for the whole data phase.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            restart_pulse <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend <= take & hwrite & (hsize == 3'h2) & (haddr[31:8] == 24'h000000);
            wr_addr <= haddr[7:0];
            restart_pulse <= wr_pend & (wr_addr == `CIS_REG_CTRL) &
                hwdata[`CIS_CTRL_RESTART_BIT];
            hrdata <= 32'h00000000;
            if (take & !hwrite & (haddr[31:8] == 24'h000000)) begin
                case (haddr[7:0])
                    `CIS_REG_STATUS: hrdata <= status_word;
                    `CIS_REG_PV: hrdata <= pv_word;
                    `CIS_REG_FV: hrdata <= fv_word;
                    `CIS_REG_RATE_YEARS: hrdata <= rate_years_word;
                    default: hrdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// *** cis_board_model.sv ***
`default_nettype none
// ****************************************
// External digit sources seen by the sequencer
// ****************************************
module cis_board_model (
    input wire logic [1:0] result_source_select,
    output logic [6:0] result_digit_in0,
    output logic [6:0] result_digit_in1,
    output logic [6:0] result_digit_in2,
    output logic [6:0] result_digit_in3,
    output logic [6:0] conv_digit0,
    output logic [6:0] conv_digit1,
    output logic [6:0] conv_digit2,
    output logic [6:0] conv_digit3
);
    timeunit 1ns;
    timeprecision 1ps;
    // The left digit carries the select, so a wrong select shows on the display.
    assign result_digit_in0 = {5'h18, result_source_select};
    assign result_digit_in1 = 7'h12;
    assign result_digit_in2 = 7'h13;
    assign result_digit_in3 = 7'h14;
    assign conv_digit0 = 7'h41;
    assign conv_digit1 = 7'h42;
    assign conv_digit2 = 7'h43;
    assign conv_digit3 = 7'h44;
endmodule
`default_nettype wire

// *** cis_properties.sv ***
`default_nettype none
module cis_props (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hresp,
    input wire logic [6:0] seg_code0,
    input wire logic [6:0] seg_code3,
    input wire logic [2:0] led_green,
    input wire logic led_done,
    input wire logic sys_reset,
    input wire logic [1:0] result_source_select,
    input wire logic [26:0] pv_out,
    input wire logic [26:0] fv_out,
    input wire logic [6:0] rate_out,
    input wire logic [5:0] years_out,
    input wire logic rate_unit_go,
    input wire logic future_unit_go,
    input wire logic doubling_unit_go,
    input wire logic converter_go,
    input wire logic [6:0] result_digit_in0
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Core resets clear mode and lights together, so only compare outside reset.
    a_green_one_hot: assert property (!sys_reset |-> led_green == ($past(result_source_select)
        == 2'h3 ? 3'h0 : 3'h1 << $past(result_source_select))) else $error("green mode light");
    a_reset_drop_prompt: assert property ($fell(sys_reset) |-> seg_code0 == 7'h16
        && seg_code3 == 7'h0E) else $error("ready prompt");
    a_reset_operands: assert property (sys_reset |-> pv_out == 27'h0 && fv_out == 27'h0
        && rate_out == 7'h01 && years_out == 6'h01) else $error("reset operands");
    a_done_until_reset: assert property ($fell(led_done) |-> sys_reset) else $error("done dropped");
    a_launch_select: assert property ($fell(future_unit_go) |-> result_source_select == 2'h1
        && rate_unit_go && doubling_unit_go) else $error("launch select");
    a_launch_pulse: assert property ($fell(future_unit_go) |=> future_unit_go ##1 led_done)
        else $error("launch pulse");
    a_conv_pulse: assert property ($fell(converter_go) |=> converter_go) else $error("conv pulse");
    a_result_shown: assert property (led_done |-> seg_code0 == $past(result_digit_in0))
        else $error("result digit");
    a_bus_okay: assert property (hresp == 1'b0) else $error("bus response");
endmodule
bind cis_input_sequencer cis_props u_props (.hclk, .hresetn, .hresp, .seg_code0, .seg_code3,
    .led_green, .led_done, .sys_reset, .result_source_select, .pv_out, .fv_out, .rate_out,
    .years_out, .rate_unit_go, .future_unit_go, .doubling_unit_go, .converter_go,
    .result_digit_in0);
`default_nettype wire

// *** testbench.sv ***
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [9:0] sw = 10'h000;
    logic [3:0] key = 4'h0;
    logic fault_in = 1'b0;
    wire logic hready;
    wire logic [31:0] hrdata;
    wire logic hreadyout, hresp, led_done, sys_reset, converter_go;
    wire logic rate_unit_go, future_unit_go, doubling_unit_go;
    wire logic [6:0] seg_code0, seg_code1, seg_code2, seg_code3, rate_out;
    wire logic [6:0] result_digit_in0, result_digit_in1, result_digit_in2, result_digit_in3;
    wire logic [6:0] conv_digit0, conv_digit1, conv_digit2, conv_digit3;
    wire logic [2:0] led_green;
    wire logic [1:0] result_source_select;
    wire logic [26:0] pv_out, fv_out;
    wire logic [5:0] years_out;
    int errors = 0;
    int checks = 0;
    int i;
    logic [31:0] rd;
    // Each row is the mode followed by the green lights it should give.
    logic [4:0] rows [4] = '{5'h01, 5'h0A, 5'h14, 5'h18};
    assign hready = hreadyout;
    cis_input_sequencer #(.SHOW_CYCLES(8)) u_dut (.*);
    cis_board_model u_board (.*);
    always #5 hclk = ~hclk;
    task results;
        if (errors == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task seg4(input logic [27:0] e);
        chk("seg", {4'h0, e}, {4'h0, seg_code0, seg_code1, seg_code2, seg_code3});
    endtask
    // Keys pass two sync flops, so they are held long enough to be seen once.
    task press(input int b, input logic [9:0] s);
        @(posedge hclk);
        sw <= s;
        key[b] <= 1'b1;
        repeat (4) @(posedge hclk);
        key <= 4'h0;
        repeat (16) @(posedge hclk);
    endtask
    // Button 0 load that looks at the display while the loaded value is shown.
    task show(input logic [9:0] s, input logic [27:0] e);
        @(posedge hclk);
        sw <= s;
        key[0] <= 1'b1;
        repeat (5) @(posedge hclk);
        seg4(e);
        key <= 4'h0;
        repeat (16) @(posedge hclk);
    endtask
    task chord;
        @(posedge hclk);
        sw <= 10'h000;
        key <= 4'hF;
        repeat (4) @(posedge hclk);
        key <= 4'h0;
        repeat (8) @(posedge hclk);
    endtask
    task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (3) @(posedge hclk);
        chk("sys_reset", 1'b0, sys_reset);
        seg4({7'h16, 7'h00, 7'h0D, 7'h0E});
        for (i = 0; i < 4; i++) begin
            chord();
            press(0, {8'h00, rows[i][4:3]});
            chk("mode", rows[i][4:3], result_source_select);
            chk("led_green", rows[i][2:0], led_green);
        end
        press(0, 10'h001);
        press(3, 10'h200);
        seg4({7'h07, 7'h25, 7'h19, 7'h1E});
        press(0, 10'h155);
        chk("pv_low", 32'h155, pv_out[9:0]);
        press(1, 10'h2AA);
        chk("pv_mid", 32'h2AA, pv_out[19:10]);
        press(2, 10'h05A);
        chk("pv_high", 32'h5A, pv_out[26:20]);
        ahb(1'b0, 32'h04, 32'h0);
        chk("status", 32'h14, rd & 32'hFF);
        ahb(1'b0, 32'h08, 32'h0);
        chk("pv_word", 32'h05AAA955, rd);
        ahb(1'b0, 32'h40, 32'h0);
        chk("unmapped", 32'h0, rd);
        @(posedge hclk);
        fault_in <= 1'b1;
        repeat (3) @(posedge hclk);
        chk("fault_digit", 32'h61, seg_code0);
        fault_in <= 1'b0;
        press(3, 10'h200);
        seg4({7'h07, 7'h25, 7'h19, 7'h1E});
        press(3, 10'h080);
        seg4({7'h06, 7'h25, 7'h01, 7'h16});
        show(10'h07F, {7'h01, 7'h16, 7'h26, 7'h7F});
        chk("rate", 32'h7F, rate_out);
        press(3, 10'h040);
        seg4({7'h05, 7'h25, 7'h22, 7'h1D});
        show(10'h03F, {7'h22, 7'h1D, 7'h26, 7'h3F});
        chk("years", 32'h3F, years_out);
        ahb(1'b0, 32'h10, 32'h0);
        chk("rate_years", 32'h3F7F, rd);
        press(3, 10'h020);
        chk("led_done", 1'b1, led_done);
        chk("result", 32'h61, seg_code0);
        chord();
        chk("reset_pv", 32'h0, pv_out);
        chk("reset_ops", {17'h0, 7'h01, 6'h01, 2'h3},
            {17'h0, rate_out, years_out, result_source_select});
        press(0, 10'h000);
        press(3, 10'h200);
        seg4({7'h08, 7'h25, 7'h0F, 7'h1E});
        show(10'h155, {7'h41, 7'h42, 7'h43, 7'h44});
        chk("fv_low", 32'h155, fv_out[9:0]);
        press(3, 10'h100);
        seg4({7'h07, 7'h25, 7'h19, 7'h1E});
        ahb(1'b1, 32'h00, 32'h1);
        repeat (8) @(posedge hclk);
        chk("restart", {2'h3, 27'h0}, {result_source_select, fv_out});
        press(3, 10'h200);
        ahb(1'b0, 32'h04, 32'h0);
        chk("none_launch", 32'h31, rd & 32'hFF);
        chk("go_idle", 32'h7, {rate_unit_go, future_unit_go, doubling_unit_go});
        results();
    end
    initial begin
        #50000;
        errors++;
        results();
    end
endmodule
`default_nettype wire
